//--- bench/scpb_properties.sv
// Port-level checker for the register bank
`timescale 1ns/100ps
module scpb_properties
	import scpb_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              rst_n,
	input wire logic              spi_sclk,
	input wire logic              spi_csb_n,
	input wire logic              spi_sdi,
	input wire logic              spi_sdo,
	input wire logic              spi_sdo_oe,
	input wire logic              rx_bit,
	input wire logic              rx_bit_valid,
	input wire scpb_clkmult_cfg_t clkmult_cfg,
	input wire logic              receiver_global_off,
	input wire logic [7:0]        lane_off_mask,
	input wire scpb_checker_t     checker_status
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] cnt;
	logic       clr;
	logic       flg;
	logic       go;
	assign cnt = checker_status.mismatch_count;
	assign clr = checker_status.err_counter_clear;
	assign flg = checker_status.seq_match_flag;
	assign go  = checker_status.checker_enable & rx_bit_valid;
	// ****************************************************************
	// Power-down and checker relations
	// ****************************************************************
	property p_master_all;
		receiver_global_off |-> lane_off_mask == 8'hFF;
	endproperty
	a_master_all: assert property (p_master_all)
		else $error("master off without all lanes off");
	property p_lane_quiet;
		spi_csb_n [*5] |=> $stable(lane_off_mask);
	endproperty
	a_lane_quiet: assert property (p_lane_quiet)
		else $error("lane mask moved without a frame");
	property p_clr_zero;
		clr |=> cnt == 8'h00;
	endproperty
	a_clr_zero: assert property (p_clr_zero)
		else $error("count not held at zero");
	property p_idle_hold;
		!go && !clr |=> $stable(cnt) && $stable(flg);
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("checker moved while idle");
	property p_step_one;
		!clr |=> cnt == $past(cnt) || cnt == $past(cnt) + 8'h01;
	endproperty
	a_step_one: assert property (p_step_one)
		else $error("count stepped by more than one");
	property p_sat;
		cnt == 8'hFF && !clr |=> cnt == 8'hFF;
	endproperty
	a_sat: assert property (p_sat)
		else $error("count wrapped");
	property p_err_flag;
		!clr ##1 cnt != $past(cnt) |-> !flg;
	endproperty
	a_err_flag: assert property (p_err_flag)
		else $error("error counted with good flag");
	property p_good_stable;
		$rose(flg) |-> $stable(cnt);
	endproperty
	a_good_stable: assert property (p_good_stable)
		else $error("good flag rose on a counted error");
	c_good: cover property ($rose(flg));
	c_sat: cover property (cnt == 8'hFF);
	c_off: cover property (receiver_global_off);
endmodule
bind scpb_register_bank scpb_properties i_scpb_properties (
	.core_clk(core_clk), .rst_n(rst_n), .spi_sclk(spi_sclk),
	.spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
	.spi_sdo_oe(spi_sdo_oe), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
	.clkmult_cfg(clkmult_cfg), .receiver_global_off(receiver_global_off),
	.lane_off_mask(lane_off_mask), .checker_status(checker_status));

//--- bench/tb_scpb_register_bank.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
module tb_scpb_register_bank import scpb_pkg::*; ;
	logic              core_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              spi_sclk = 1'b0;
	logic              spi_csb_n = 1'b1;
	logic              spi_sdi = 1'b0;
	logic              rx_bit = 1'b0;
	logic              rx_bit_valid = 1'b0;
	logic              spi_sdo;
	logic              spi_sdo_oe;
	logic              receiver_global_off;
	logic [7:0]        lane_off_mask;
	scpb_clkmult_cfg_t clkmult_cfg;
	scpb_checker_t     checker_status;
	int                failures = 0;
	int                num_checks = 0;
	int                cycles = 0;
	int                warm = 0;
	logic [7:0]        rd;
	logic              oe = 1'b0;
	logic [14:0]       gen = 15'h7FFF;
	logic [14:0]       hist = 15'h0000;
	logic              c_en = 1'b0;
	logic              c_poly = 1'b0;
	logic [7:0]        e_cnt = 8'h00;
	logic              e_flag = 1'b0;
	logic [14:0]       ta [13] = '{15'h1B0, 15'h1B9, 15'h1BC, 15'h1BE, 15'h1BF,
		15'h1C0, 15'h1C1, 15'h1C4, 15'h1B5, 15'h1BB, 15'h1C5, 15'h14C, 15'h1B1};
	logic [7:0]        tw [13] = '{8'h00, 8'h24, 8'h0D, 8'h02, 8'h8E, 8'h2A,
		8'h2A, 8'h7E, 8'h8A, 8'hFF, 8'h5C, 8'hFF, 8'hFF};
	logic [7:0]        tr [13] = '{8'h00, 8'h24, 8'h0D, 8'h02, 8'h8E, 8'h2A,
		8'h2A, 8'h7E, 8'h8A, 8'h1F, 8'h5C, 8'h00, 8'h00};
	logic [14:0]       ra [15] = '{15'h14B, 15'h14C, 15'h1B0, 15'h1B5, 15'h1B9,
		15'h1BB, 15'h1BC, 15'h1BE, 15'h1BF, 15'h1C0, 15'h1C1, 15'h1C4,
		15'h1C5, 15'h200, 15'h201};
	logic [7:0]        rv [15] = '{8'h00, 8'h00, 8'hFA, 8'h83, 8'h34, 8'h0C,
		8'h00, 8'h00, 8'h8D, 8'h2E, 8'h24, 8'h33, 8'h08, 8'h00, 8'h00};

	scpb_register_bank i_scpb_register_bank (
		.core_clk(core_clk), .rst_n(rst_n), .spi_sclk(spi_sclk),
		.spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
		.clkmult_cfg(clkmult_cfg), .receiver_global_off(receiver_global_off),
		.lane_off_mask(lane_off_mask), .checker_status(checker_status));

	always #4 core_clk = ~core_clk;
	// Hang guard, about twice the roughly 14800 cycles needed
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			complete_run();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task complete_run();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp, input string w);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	// Each SCLK phase lasts 5 clocks, above the 4-clock minimum
	task spi(input logic [15:0] ins, input logic [7:0] wd);
		logic [23:0] f;
		f = {ins, wd};
		spi_csb_n = 1'b0;
		tick(5);
		for (int i = 23; i >= 0; i--) begin
			spi_sdi = f[i];
			spi_sclk = 1'b0;
			tick(5);
			if (i < 8)
				rd[i] = spi_sdo;
			if (i == 4)
				oe = spi_sdo_oe;
			spi_sclk = 1'b1;
			tick(5);
		end
		spi_sclk = 1'b0;
		tick(5);
		spi_csb_n = 1'b1;
		tick(6);
	endtask
	task rdchk(input logic [14:0] a, input logic [7:0] exp);
		spi({1'b1, a}, 8'h00);
		check(rd, exp, "read");
		check({7'h00, oe}, 8'h01, "oe in read");
		check({7'h00, spi_sdo_oe}, 8'h00, "oe after frame");
	endtask
	task set_ctrl(input logic [7:0] v);
		spi({1'b0, OFS_SEQ_CTRL}, v);
		check({7'h00, oe}, 8'h00, "oe in write");
		c_en = v[0];
		c_poly = v[2];
		if (!v[0])
			warm = 0;
		if (v[1])
			e_cnt = 8'h00;
	endtask
	// Feed n generated bits, inverting bit number flip; model tracks outcome
	task send(input int n, input logic dp, input int flip);
		logic b;
		for (int i = 0; i < n; i++) begin
			b = dp ? gen[14] ^ gen[13] : gen[6] ^ gen[5];
			gen = {gen[13:0], b};
			b = (i == flip) ? ~b : b;
			rx_bit = b;
			rx_bit_valid = 1'b1;
			if (c_en) begin
				if (warm >= (c_poly ? 15 : 7)) begin
					e_flag = b == (c_poly ? hist[14] ^ hist[13] : hist[6] ^ hist[5]);
					if (!e_flag && e_cnt != 8'hFF)
						e_cnt++;
				end else
					warm++;
				hist = {hist[13:0], b};
			end
			tick(1);
		end
		rx_bit_valid = 1'b0;
		tick(2);
		check(checker_status.mismatch_count, e_cnt, "count");
		check({7'h00, checker_status.seq_match_flag}, {7'h00, e_flag}, "flag");
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		tick(4);
		rst_n = 1'b1;
		tick(4);
		for (int i = 0; i < 15; i++)
			rdchk(ra[i], rv[i]);
		$display("test reset_values done");
		for (int i = 0; i < 13; i++) begin
			spi({1'b0, ta[i]}, tw[i]);
			rdchk(ta[i], tr[i]);
		end
		check(clkmult_cfg.varactor_a, 8'h7E, "cfg");
		check(clkmult_cfg.power_setting, 8'h00, "cfg");
		$display("test tuning_regs done");
		spi({1'b0, OFS_LANE_PD}, 8'hA5);
		check(lane_off_mask, 8'hA5, "lanes");
		spi({1'b0, OFS_RX_MASTER}, 8'hFF);
		rdchk(OFS_RX_MASTER, 8'h01);
		check({7'h00, receiver_global_off}, 8'h01, "master");
		check(lane_off_mask, 8'hFF, "lanes");
		spi({1'b0, OFS_RX_MASTER}, 8'h00);
		check(lane_off_mask, 8'hA5, "lanes");
		$display("test power_down done");
		set_ctrl(8'h01);
		send(40, 1'b0, -1);
		rdchk(OFS_SEQ_CTRL, 8'h41);
		send(30, 1'b0, 10);
		rdchk(OFS_SEQ_ERR, e_cnt);
		set_ctrl(8'h00);
		send(20, 1'b0, 3);
		set_ctrl(8'h06);
		tick(2);
		check(checker_status.mismatch_count, 8'h00, "clear");
		check({5'h00, checker_status[11:9]}, 8'h03, "ctrl");
		set_ctrl(8'h05);
		send(60, 1'b1, 30);
		$display("test checker done");
		set_ctrl(8'h00);
		set_ctrl(8'h01);
		send(800, 1'b1, -1);
		rdchk(OFS_SEQ_ERR, e_cnt);
		$display("test saturation done");
		complete_run();
	end
endmodule

//--- hdl/scpb_register_bank.sv
// Serial-port register bank: sequence checker, clock multiplier, power-down
`timescale 1ns/100ps

module scpb_register_bank
	import scpb_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              spi_sclk,
	input  wire logic              spi_csb_n,
	input  wire logic              spi_sdi,
	output logic                   spi_sdo,
	output logic                   spi_sdo_oe,
	input  wire logic              rx_bit,
	input  wire logic              rx_bit_valid,
	output scpb_clkmult_cfg_t      clkmult_cfg,
	output logic                   receiver_global_off,
	output logic [7:0]             lane_off_mask,
	output scpb_checker_t          checker_status
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0] sclk_sync_r;
	logic [1:0] csb_sync_r;
	logic [1:0] sdi_sync_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sclk_sync_r <= 3'h0;
			csb_sync_r  <= 2'h3;
			sdi_sync_r  <= 2'h0;
		end else begin
			sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
			csb_sync_r  <= {csb_sync_r[0], spi_csb_n};
			sdi_sync_r  <= {sdi_sync_r[0], spi_sdi};
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic csb_high;
	logic sdi_s;

	assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
	assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
	assign csb_high  = csb_sync_r[1];
	assign sdi_s     = sdi_sync_r[1];

	// ****************************************************************
	// Serial port state
	// ****************************************************************
	scpb_spi_state_t    st_r, st_nxt;
	logic [4:0]         bitcnt_r, bitcnt_nxt;
	logic [INSTR_W-1:0] sh_in_r, sh_in_nxt;
	logic [DATA_W-1:0]  sh_out_r, sh_out_nxt;
	logic [ADDR_W-1:0]  addr_r, addr_nxt;
	logic               rd_r, rd_nxt;
	logic               sdo_r, sdo_nxt;
	logic               wr_stb;
	logic [ADDR_W-1:0]  wr_addr;
	logic [7:0]         wr_data;
	logic [7:0]         rd_data;
	logic [ADDR_W-1:0]  rd_addr;

	always_comb begin
		st_nxt     = st_r;
		bitcnt_nxt = bitcnt_r;
		sh_in_nxt  = sh_in_r;
		sh_out_nxt = sh_out_r;
		addr_nxt   = addr_r;
		rd_nxt     = rd_r;
		sdo_nxt    = sdo_r;
		wr_stb     = 1'b0;
		wr_addr    = addr_r;
		wr_data    = {sh_in_r[DATA_W-2:0], sdi_s};
		rd_addr    = addr_r;
		if (csb_high) begin
			st_nxt     = SCPB_ST_IDLE;
			bitcnt_nxt = 5'h0;
			sdo_nxt    = 1'b0;
		end else begin
			unique case (st_r)
				SCPB_ST_IDLE: begin
					st_nxt = SCPB_ST_INSTR;
				end
				SCPB_ST_INSTR: begin
					if (sclk_rise) begin
						sh_in_nxt  = {sh_in_r[INSTR_W-2:0], sdi_s};
						bitcnt_nxt = bitcnt_r + 5'h1;
						if (bitcnt_r == INSTR_LAST) begin
							// Address arrives whole with this bit
							rd_addr    = sh_in_nxt[ADDR_W-1:0];
							addr_nxt   = sh_in_nxt[ADDR_W-1:0];
							rd_nxt     = sh_in_nxt[RD_BIT];
							sh_out_nxt = rd_data;
							bitcnt_nxt = 5'h0;
							st_nxt     = SCPB_ST_DATA;
						end
					end
				end
				SCPB_ST_DATA: begin
					if (sclk_rise) begin
						sh_in_nxt  = {sh_in_r[INSTR_W-2:0], sdi_s};
						bitcnt_nxt = bitcnt_r + 5'h1;
						if (bitcnt_r[2:0] == BYTE_LAST) begin
							// Streaming: next byte at the next address
							wr_stb     = ~rd_r;
							addr_nxt   = addr_r + 15'h1;
							rd_addr    = addr_nxt;
							sh_out_nxt = rd_data;
							bitcnt_nxt = 5'h0;
						end
					end else if (sclk_fall && rd_r) begin
						sdo_nxt    = sh_out_r[DATA_W-1];
						sh_out_nxt = {sh_out_r[DATA_W-2:0], 1'b0};
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r     <= SCPB_ST_IDLE;
			bitcnt_r <= 5'h0;
			sh_in_r  <= 16'h0000;
			sh_out_r <= 8'h00;
			addr_r   <= 15'h0000;
			rd_r     <= 1'b0;
			sdo_r    <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			bitcnt_r <= bitcnt_nxt;
			sh_in_r  <= sh_in_nxt;
			sh_out_r <= sh_out_nxt;
			addr_r   <= addr_nxt;
			rd_r     <= rd_nxt;
			sdo_r    <= sdo_nxt;
		end
	end

	assign spi_sdo    = sdo_r;
	assign spi_sdo_oe = rd_r & (st_r == SCPB_ST_DATA) & ~csb_high;

	// ****************************************************************
	// Register file and sequence checker
	// ****************************************************************
	logic [7:0]        ctrl_r, ctrl_nxt;
	logic              flag_r, flag_nxt;
	logic [7:0]        errcnt_r, errcnt_nxt;
	logic [HIST_W-1:0] hist_r, hist_nxt;
	logic [3:0]        warm_r, warm_nxt;
	scpb_clkmult_cfg_t cm_r, cm_nxt;
	logic              mpd_r, mpd_nxt;
	logic [7:0]        lpd_r, lpd_nxt;
	logic              chk_en;
	logic              predict;
	logic [3:0]        warm_need;

	assign chk_en = ctrl_r[BIT_CHECKER_ENABLE];

	always_comb begin
		if (ctrl_r[BIT_POLY_SELECT]) begin
			predict   = hist_r[P15_TAP_HI] ^ hist_r[P15_TAP_LO];
			warm_need = WARM_P15;
		end else begin
			predict   = hist_r[P7_TAP_HI] ^ hist_r[P7_TAP_LO];
			warm_need = WARM_P7;
		end
	end

	always_comb begin
		ctrl_nxt   = ctrl_r;
		flag_nxt   = flag_r;
		errcnt_nxt = errcnt_r;
		hist_nxt   = hist_r;
		warm_nxt   = warm_r;
		cm_nxt     = cm_r;
		mpd_nxt    = mpd_r;
		lpd_nxt    = lpd_r;
		if (!chk_en) begin
			warm_nxt = 4'h0;
		end else if (rx_bit_valid) begin
			// Self-synchronising: history is the received stream
			hist_nxt = {hist_r[HIST_W-2:0], rx_bit};
			if (warm_r != warm_need) begin
				warm_nxt = warm_r + 4'h1;
			end else begin
				flag_nxt = (predict == rx_bit);
				if (predict != rx_bit && errcnt_r != ERR_CNT_MAX) begin
					errcnt_nxt = errcnt_r + 8'h01;
				end
			end
		end
		if (wr_stb) begin
			unique case (wr_addr)
				OFS_SEQ_CTRL:  ctrl_nxt = wr_data & MASK_SEQ_CTRL;
				OFS_CM_PWR:    cm_nxt.power_setting   = wr_data;
				OFS_CM_VTUNE:  cm_nxt.varactor_tune   = wr_data;
				OFS_CM_CP_A:   cm_nxt.charge_pump_a   = wr_data;
				OFS_CM_OBIAS:  cm_nxt.osc_bias = wr_data & MASK_OBIAS;
				OFS_CM_OCTRL:  cm_nxt.osc_control     = wr_data;
				OFS_CM_OPWR:   cm_nxt.osc_power       = wr_data;
				OFS_CM_OCAL:   cm_nxt.osc_calibration = wr_data;
				OFS_CM_LOCK:   cm_nxt.lock_counter    = wr_data;
				OFS_CM_CP_B:   cm_nxt.charge_pump_b   = wr_data;
				OFS_CM_VAR_A:  cm_nxt.varactor_a      = wr_data;
				OFS_CM_VAR_B:  cm_nxt.varactor_b      = wr_data;
				OFS_RX_MASTER: mpd_nxt = wr_data[BIT_RECEIVER_OFF];
				OFS_LANE_PD:   lpd_nxt = wr_data;
				default:       ;
			endcase
		end
		if (ctrl_r[BIT_ERR_COUNTER_CLR]) begin
			errcnt_nxt = RST_ERR_CNT;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_r   <= RST_SEQ_CTRL;
			flag_r   <= 1'b0;
			errcnt_r <= RST_ERR_CNT;
			hist_r   <= 15'h0000;
			warm_r   <= 4'h0;
			cm_r     <= '{power_setting:   RST_CM_PWR,
			              varactor_tune:   RST_CM_VTUNE,
			              charge_pump_a:   RST_CM_CP_A,
			              osc_bias:        RST_CM_OBIAS,
			              osc_control:     RST_CM_OCTRL,
			              osc_power:       RST_CM_OPWR,
			              osc_calibration: RST_CM_OCAL,
			              lock_counter:    RST_CM_LOCK,
			              charge_pump_b:   RST_CM_CP_B,
			              varactor_a:      RST_CM_VAR_A,
			              varactor_b:      RST_CM_VAR_B};
			mpd_r    <= RST_RX_PD[BIT_RECEIVER_OFF];
			lpd_r    <= RST_RX_PD;
		end else begin
			ctrl_r   <= ctrl_nxt;
			flag_r   <= flag_nxt;
			errcnt_r <= errcnt_nxt;
			hist_r   <= hist_nxt;
			warm_r   <= warm_nxt;
			cm_r     <= cm_nxt;
			mpd_r    <= mpd_nxt;
			lpd_r    <= lpd_nxt;
		end
	end

	// ****************************************************************
	// Read-back
	// ****************************************************************
	always_comb begin
		rd_data = 8'h00;
		unique case (rd_addr)
			OFS_SEQ_CTRL: begin
				rd_data = ctrl_r;
				rd_data[BIT_SEQ_MATCH_FLAG] = flag_r;
			end
			OFS_SEQ_ERR:   rd_data = errcnt_r;
			OFS_CM_PWR:    rd_data = cm_r.power_setting;
			OFS_CM_VTUNE:  rd_data = cm_r.varactor_tune;
			OFS_CM_CP_A:   rd_data = cm_r.charge_pump_a;
			OFS_CM_OBIAS:  rd_data = cm_r.osc_bias;
			OFS_CM_OCTRL:  rd_data = cm_r.osc_control;
			OFS_CM_OPWR:   rd_data = cm_r.osc_power;
			OFS_CM_OCAL:   rd_data = cm_r.osc_calibration;
			OFS_CM_LOCK:   rd_data = cm_r.lock_counter;
			OFS_CM_CP_B:   rd_data = cm_r.charge_pump_b;
			OFS_CM_VAR_A:  rd_data = cm_r.varactor_a;
			OFS_CM_VAR_B:  rd_data = cm_r.varactor_b;
			OFS_RX_MASTER: rd_data[BIT_RECEIVER_OFF] = mpd_r;
			OFS_LANE_PD:   rd_data = lpd_r;
			default:       rd_data = 8'h00;
		endcase
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign clkmult_cfg = cm_r;
	assign receiver_global_off = mpd_r;
	assign lane_off_mask = lpd_r | {8{mpd_r}};
	assign checker_status = '{checker_enable:    ctrl_r[BIT_CHECKER_ENABLE],
	                          err_counter_clear: ctrl_r[BIT_ERR_COUNTER_CLR],
	                          poly_select:       ctrl_r[BIT_POLY_SELECT],
	                          seq_match_flag:    flag_r,
	                          mismatch_count:    errcnt_r};

endmodule

//--- shared/scpb_pkg.sv
// Constants and types for the checker, clock-multiplier and power-down bank
package scpb_pkg;

	// ****************************************************************
	// Serial port framing
	// ****************************************************************
	localparam int unsigned ADDR_W   = 15;
	localparam int unsigned INSTR_W  = 16;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned RD_BIT   = 15;
	localparam logic [4:0]  INSTR_LAST = 5'hF;
	localparam logic [2:0]  BYTE_LAST  = 3'h7;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFS_SEQ_CTRL   = 15'h014B;
	localparam logic [ADDR_W-1:0] OFS_SEQ_ERR    = 15'h014C;
	localparam logic [ADDR_W-1:0] OFS_CM_PWR     = 15'h01B0;
	localparam logic [ADDR_W-1:0] OFS_CM_VTUNE   = 15'h01B5;
	localparam logic [ADDR_W-1:0] OFS_CM_CP_A    = 15'h01B9;
	localparam logic [ADDR_W-1:0] OFS_CM_OBIAS   = 15'h01BB;
	localparam logic [ADDR_W-1:0] OFS_CM_OCTRL   = 15'h01BC;
	localparam logic [ADDR_W-1:0] OFS_CM_OPWR    = 15'h01BE;
	localparam logic [ADDR_W-1:0] OFS_CM_OCAL    = 15'h01BF;
	localparam logic [ADDR_W-1:0] OFS_CM_LOCK    = 15'h01C0;
	localparam logic [ADDR_W-1:0] OFS_CM_CP_B    = 15'h01C1;
	localparam logic [ADDR_W-1:0] OFS_CM_VAR_A   = 15'h01C4;
	localparam logic [ADDR_W-1:0] OFS_CM_VAR_B   = 15'h01C5;
	localparam logic [ADDR_W-1:0] OFS_RX_MASTER  = 15'h0200;
	localparam logic [ADDR_W-1:0] OFS_LANE_PD    = 15'h0201;

	// ****************************************************************
	// Field positions and write masks
	// ****************************************************************
	localparam int unsigned BIT_CHECKER_ENABLE   = 0;
	localparam int unsigned BIT_ERR_COUNTER_CLR  = 1;
	localparam int unsigned BIT_POLY_SELECT      = 2;
	localparam int unsigned BIT_SEQ_MATCH_FLAG   = 6;
	localparam int unsigned BIT_RECEIVER_OFF     = 0;
	localparam logic [7:0]  MASK_SEQ_CTRL        = 8'h07;
	localparam logic [7:0]  MASK_OBIAS           = 8'h1F;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_SEQ_CTRL = 8'h00;
	localparam logic [7:0] RST_CM_PWR   = 8'hFA;
	localparam logic [7:0] RST_CM_VTUNE = 8'h83;
	localparam logic [7:0] RST_CM_CP_A  = 8'h34;
	localparam logic [7:0] RST_CM_OBIAS = 8'h0C;
	localparam logic [7:0] RST_CM_OCTRL = 8'h00;
	localparam logic [7:0] RST_CM_OPWR  = 8'h00;
	localparam logic [7:0] RST_CM_OCAL  = 8'h8D;
	localparam logic [7:0] RST_CM_LOCK  = 8'h2E;
	localparam logic [7:0] RST_CM_CP_B  = 8'h24;
	localparam logic [7:0] RST_CM_VAR_A = 8'h33;
	localparam logic [7:0] RST_CM_VAR_B = 8'h08;
	localparam logic [7:0] RST_RX_PD    = 8'h00;
	localparam logic [7:0] RST_ERR_CNT  = 8'h00;
	localparam logic [7:0] ERR_CNT_MAX  = 8'hFF;

	// ****************************************************************
	// Sequence checker
	// ****************************************************************
	localparam int unsigned HIST_W      = 15;
	localparam int unsigned P7_TAP_HI   = 6;
	localparam int unsigned P7_TAP_LO   = 5;
	localparam int unsigned P15_TAP_HI  = 14;
	localparam int unsigned P15_TAP_LO  = 13;
	localparam logic [3:0]  WARM_P7     = 4'h7;
	localparam logic [3:0]  WARM_P15    = 4'hF;

	typedef enum logic [1:0] {
		SCPB_ST_IDLE,
		SCPB_ST_INSTR,
		SCPB_ST_DATA
	} scpb_spi_state_t;

	typedef struct packed {
		logic [7:0] power_setting;
		logic [7:0] varactor_tune;
		logic [7:0] charge_pump_a;
		logic [7:0] osc_bias;
		logic [7:0] osc_control;
		logic [7:0] osc_power;
		logic [7:0] osc_calibration;
		logic [7:0] lock_counter;
		logic [7:0] charge_pump_b;
		logic [7:0] varactor_a;
		logic [7:0] varactor_b;
	} scpb_clkmult_cfg_t;

	typedef struct packed {
		logic       checker_enable;
		logic       err_counter_clear;
		logic       poly_select;
		logic       seq_match_flag;
		logic [7:0] mismatch_count;
	} scpb_checker_t;

endpackage
